// [core/swire_master.sv]
// bus master for the single-wire pulse-width sensor link
`timescale 1ns/1ns
`include "swire_defines.svh"
module swire_master #(
   parameter int CNT_W        = `CNT_W,
   parameter int RESET_CYC    = `RESET_DRIVE_CYC
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   // open-drain data line
   input  wire logic              swd_in,
   output logic                   swd_out,
   output logic                   swd_oe,
   // command request
   input  wire logic              cmd_valid,
   input  wire swire_pkg::cmd_e   cmd_code,
   output logic                   cmd_ready,
   // result of each symbol
   output logic                   done,
   output logic                   rd_bit,
   output logic                   collided,
   // asynchronous events seen on the line
   output logic                   attn_seen,
   output logic                   reset_seen
);
   initial
   begin
      // a drive shorter than the least reset width breaks the line's reset
      if (CNT_W < 16 || RESET_CYC < `RESET_MIN_CYC || RESET_CYC >= (1 << CNT_W))
         $error("swire_master: counter too narrow or reset too short");
   end

   typedef enum logic [2:0] {
      ST_PWRUP,
      ST_IDLE,
      ST_DRIVE,
      ST_WAIT_HIGH,
      ST_GAP,
      ST_TRAIN
   } state_e;

   typedef struct packed {
      state_e              st;        // sequencer state
      logic [CNT_W-1:0]    cnt;       // drive / power-up reset timer
      logic [CNT_W-1:0]    low_len;   // length of current low
      logic [CNT_W-1:0]    hi_len;    // length of current high
      logic [3:0]          train;     // training zeros remaining
      swire_pkg::cmd_e     cmd;       // symbol being sent
      logic                own;       // master owns the current low
      logic                swd_out;
      logic                swd_oe;
      logic                cmd_ready;
      logic                done;
      logic                rd_bit;
      logic                collided;
      logic                attn_seen;
      logic                reset_seen;
   } state_s;

   state_s             s_reg;        // registered state
   state_s             s_next;       // next state
   swire_pkg::sym_e    sym;          // class of measured low

   // drive width for a command
   function automatic logic [CNT_W-1:0] width_of(input swire_pkg::cmd_e c);
      unique case (c)
         swire_pkg::CMD_WRITE1: width_of = CNT_W'(`LONG_PULSE_CYC);
         swire_pkg::CMD_START:  width_of = CNT_W'(`START_PULSE_CYC);
         swire_pkg::CMD_RESET:  width_of = CNT_W'(RESET_CYC);
         default:               width_of = CNT_W'(`SHORT_PULSE_CYC);
      endcase
   endfunction

   // expected class of a command's own pulse
   function automatic swire_pkg::sym_e expect_of(input swire_pkg::cmd_e c);
      unique case (c)
         swire_pkg::CMD_WRITE1: expect_of = swire_pkg::SYM_ONE;
         swire_pkg::CMD_START:  expect_of = swire_pkg::SYM_START;
         swire_pkg::CMD_RESET:  expect_of = swire_pkg::SYM_RESET;
         default:               expect_of = swire_pkg::SYM_ZERO;
      endcase
   endfunction

   // pulse classifier on the running low length
   low_classifier #(.CNT_W(CNT_W)) u_class (
      .low_len (s_reg.low_len),
      .sym     (sym)
   );

   // next-state logic
   always_comb
   begin
      s_next            = s_reg;
      s_next.done       = 1'b0;
      s_next.attn_seen  = 1'b0;
      s_next.reset_seen = 1'b0;
      s_next.cmd_ready  = 1'b0;
      // time line low and high
      if (!swd_in)
      begin
         s_next.low_len = (&s_reg.low_len) ? s_reg.low_len : s_reg.low_len + 1'b1;
         s_next.hi_len  = '0;
      end
      else
      begin
         s_next.hi_len  = (&s_reg.hi_len) ? s_reg.hi_len : s_reg.hi_len + 1'b1;
         s_next.low_len = '0;
      end
      unique case (s_reg.st)
         // power-up reset before any other operation
         ST_PWRUP:
         begin
            s_next.swd_oe  = 1'b1;
            s_next.swd_out = 1'b0;
            s_next.cnt     = s_reg.cnt + 1'b1;
            if (s_reg.cnt >= CNT_W'(RESET_CYC))
            begin
               s_next.swd_oe = 1'b0;
               s_next.cmd    = swire_pkg::CMD_RESET;
               s_next.own    = 1'b1;
               s_next.st     = ST_WAIT_HIGH;
            end
         end
         // wait for idle, then accept commands
         ST_IDLE:
         begin
            if (!swd_in)
            begin
               s_next.own = 1'b0;           // foreign low, likely attention
               s_next.st  = ST_WAIT_HIGH;
            end
            else if (s_reg.hi_len >= CNT_W'(`MIN_IDLE_CYC))
            begin
               s_next.cmd_ready = 1'b1;
               if (cmd_valid && s_reg.cmd_ready)
               begin
                  s_next.cmd_ready = 1'b0;
                  s_next.cmd       = cmd_code;
                  s_next.own       = 1'b1;
                  s_next.swd_oe    = 1'b1;
                  s_next.swd_out   = 1'b0;
                  s_next.cnt       = width_of(cmd_code);
                  s_next.st        = ST_DRIVE;
               end
            end
         end
         // hold line low for the symbol width; no upper reset limit
         ST_DRIVE:
         begin
            s_next.cnt = s_reg.cnt - 1'b1;
            if (s_reg.cnt <= CNT_W'(1))
            begin
               s_next.swd_oe = 1'b0;
               s_next.st     = ST_WAIT_HIGH;
            end
         end
         // line released; classify at the rising edge
         ST_WAIT_HIGH:
         begin
            if (swd_in && s_reg.low_len != '0)
            begin
               s_next.st = ST_GAP;
               if (sym == swire_pkg::SYM_RESET)
               begin
                  s_next.reset_seen = 1'b1;
                  s_next.train      = 4'(`TRAIN_BITS);
               end
               else if (sym == swire_pkg::SYM_ATTN)
                  s_next.attn_seen = 1'b1;
               if (s_reg.own)
               begin
                  s_next.done     = 1'b1;
                  // read value: stretched low marks a one
                  s_next.rd_bit   = (s_reg.cmd == swire_pkg::CMD_READ)
                                    && (sym == swire_pkg::SYM_ONE);
                  // longer foreign symbol overrode ours; user retries
                  s_next.collided = (sym != expect_of(s_reg.cmd))
                                    && !(s_reg.cmd == swire_pkg::CMD_READ
                                         && sym == swire_pkg::SYM_ONE);
               end
            end
         end
         // idle gap after each symbol, then training zeros if due
         ST_GAP:
         begin
            if (!swd_in)
            begin
               s_next.own = 1'b0;
               s_next.st  = ST_WAIT_HIGH;
            end
            else if (s_reg.hi_len >= CNT_W'(`MIN_IDLE_CYC))
               s_next.st = (s_reg.train != 4'h0) ? ST_TRAIN : ST_IDLE;
         end
         // send one training zero, no start before it
         ST_TRAIN:
         begin
            s_next.train   = s_reg.train - 4'h1;
            s_next.cmd     = swire_pkg::CMD_WRITE0;
            s_next.own     = 1'b0;
            s_next.swd_oe  = 1'b1;
            s_next.swd_out = 1'b0;
            s_next.cnt     = CNT_W'(`SHORT_PULSE_CYC);
            s_next.st      = ST_DRIVE;
         end
      endcase
   end

   // state register with synchronous reset
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         s_reg         <= '0;
         s_reg.st      <= ST_PWRUP;
         s_reg.cmd     <= swire_pkg::CMD_WRITE0;
         s_reg.hi_len  <= '0;
      end
      else
         s_reg <= s_next;
   end

   // outputs straight from the state register
   assign swd_out    = s_reg.swd_out;
   assign swd_oe     = s_reg.swd_oe;
   assign cmd_ready  = s_reg.cmd_ready;
   assign done       = s_reg.done;
   assign rd_bit     = s_reg.rd_bit;
   assign collided   = s_reg.collided;
   assign attn_seen  = s_reg.attn_seen;
   assign reset_seen = s_reg.reset_seen;
endmodule

// [core/swire_defines.svh]
// timing constants for the single-wire pulse-width bus master
`ifndef SWIRE_DEFINES_SVH
`define SWIRE_DEFINES_SVH
`define CLK_PERIOD_NS      10
`define CLK_MHZ            100
// pulse widths in nanoseconds, as printed
`define MIN_IDLE_NS        11000
`define SHORT_PULSE_NS     14400
`define LONG_PULSE_NS      42000
`define START_PULSE_NS     94000
`define READ_ONE_MIN_NS    28300
`define ATTN_MIN_NS        165000
`define RESET_MIN_NS       354000
`define RESET_DRIVE_NS     400000
// cycle counts derived from the 100 MHz clock (least times round up)
`define NS_TO_CYC(ns)      (((ns) * `CLK_MHZ + 999) / 1000)
`define MIN_IDLE_CYC       `NS_TO_CYC(`MIN_IDLE_NS)
`define SHORT_PULSE_CYC    `NS_TO_CYC(`SHORT_PULSE_NS)
`define LONG_PULSE_CYC     `NS_TO_CYC(`LONG_PULSE_NS)
`define START_PULSE_CYC    `NS_TO_CYC(`START_PULSE_NS)
`define RESET_DRIVE_CYC    `NS_TO_CYC(`RESET_DRIVE_NS)
`define RESET_MIN_CYC      `NS_TO_CYC(`RESET_MIN_NS)
// classification thresholds placed between adjacent symbol ranges
`define THR_ONE_NS         22000
`define THR_START_NS       62000
`define THR_ATTN_NS        137000
`define THR_RESET_NS       291000
`define THR_ONE_CYC        `NS_TO_CYC(`THR_ONE_NS)
`define THR_START_CYC      `NS_TO_CYC(`THR_START_NS)
`define THR_ATTN_CYC       `NS_TO_CYC(`THR_ATTN_NS)
`define THR_RESET_CYC      `NS_TO_CYC(`THR_RESET_NS)
`define TRAIN_BITS         8
`define CNT_W              16
`endif

// [core/swire_pkg.sv]
// types shared by the single-wire bus master
package swire_pkg;
   // command codes from the user side
   typedef enum logic [2:0] {
      CMD_WRITE0,
      CMD_WRITE1,
      CMD_READ,
      CMD_START,
      CMD_RESET
   } cmd_e;
   // symbol classes by low duration
   typedef enum logic [2:0] {
      SYM_ZERO,
      SYM_ONE,
      SYM_START,
      SYM_ATTN,
      SYM_RESET
   } sym_e;
endpackage

// [core/low_classifier.sv]
// classifies a finished low pulse by its length
`timescale 1ns/1ns
`include "swire_defines.svh"
module low_classifier #(
   parameter int CNT_W = `CNT_W
) (
   // measured length
   input  wire logic [CNT_W-1:0] low_len,
   // class of the pulse
   output swire_pkg::sym_e       sym
);
   // compare against thresholds, longest first
   always_comb
   begin
      if (low_len >= CNT_W'(`THR_RESET_CYC))
         sym = swire_pkg::SYM_RESET;
      else if (low_len >= CNT_W'(`THR_ATTN_CYC))
         sym = swire_pkg::SYM_ATTN;
      else if (low_len >= CNT_W'(`THR_START_CYC))
         sym = swire_pkg::SYM_START;
      else if (low_len >= CNT_W'(`THR_ONE_CYC))
         sym = swire_pkg::SYM_ONE;
      else
         sym = swire_pkg::SYM_ZERO;
   end
endmodule

// [dv/swm_assertions.sv]
// assertion checker on the single-wire bus master ports
`timescale 1ns/1ns
`include "swire_defines.svh"
module swm_chk #(parameter int RESET_CYC = `RESET_DRIVE_CYC) (
   // watched ports
   input wire logic            core_clk,
   input wire logic            reset_n,
   input wire logic            swd_in,
   input wire logic            swd_oe,
   input wire logic            cmd_valid,
   input wire swire_pkg::cmd_e cmd_code,
   input wire logic            cmd_ready,
   input wire logic            done,
   input wire logic            rd_bit,
   input wire logic            collided,
   input wire logic            attn_seen
);
   logic [15:0]     oe_len, lo_len, lo_last, hi_len, want; // run lengths, width due
   logic            pend;   // command taken, done not yet seen
   swire_pkg::cmd_e code_q; // last command taken
   wire logic       take     = cmd_valid && cmd_ready;
   wire logic       rd_done  = done && code_q == swire_pkg::CMD_READ;
   wire logic       own_done = done && pend && code_q != swire_pkg::CMD_RESET;
   wire logic       over_len = lo_last >= `THR_ATTN_CYC; // overridden by a longer symbol
   wire logic       attn_len = lo_last >= `THR_ATTN_CYC && lo_last < `THR_RESET_CYC;
   // run lengths of drive, low and high, and the command in flight
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         {pend, oe_len, lo_len, hi_len, lo_last, want} <= '0;
         code_q <= swire_pkg::CMD_WRITE0;
      end
      else
      begin
         oe_len  <= swd_oe ? oe_len + 16'h1 : 16'h0;
         lo_len  <= swd_in ? 16'h0 : lo_len + 16'h1;
         hi_len  <= !swd_in ? 16'h0 : hi_len + {15'h0, hi_len != 16'hffff};
         lo_last <= (swd_in && lo_len != 16'h0) ? lo_len : lo_last;
         pend    <= take || (pend && !done);
         code_q  <= take ? cmd_code : code_q;
         want    <= !take ? want : cmd_code == swire_pkg::CMD_WRITE1 ? 16'(`LONG_PULSE_CYC)
            : cmd_code == swire_pkg::CMD_START ? 16'(`START_PULSE_CYC)
            : cmd_code == swire_pkg::CMD_RESET ? 16'(RESET_CYC) : 16'(`SHORT_PULSE_CYC);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_take; cmd_valid && cmd_ready; endsequence
   sequence s_drive; swd_oe && !cmd_ready; endsequence
   a_take_drive: assert property (s_take |=> s_drive)
      else $error("taken command not driven");
   a_ready_line: assert property (cmd_ready |-> !swd_oe && swd_in)
      else $error("ready while line busy");
   a_idle_ready: assert property (cmd_ready |-> hi_len >= `MIN_IDLE_CYC - 3)
      else $error("ready before idle gap");
   a_pulse_width: assert property (pend && $fell(swd_oe) |-> oe_len == want)
      else $error("drive width wrong");
   a_done_release: assert property (pend && $rose(swd_in) |-> ##[0:3] done)
      else $error("no done after release");
   a_read_value: assert property (rd_done |-> rd_bit == (lo_last >= `THR_ONE_CYC))
      else $error("read value wrong");
   a_attn_override: assert property (own_done |-> collided == over_len)
      else $error("collision flag wrong");
   a_attn_length: assert property (attn_seen |-> attn_len)
      else $error("attention length wrong");
endmodule
bind swire_master swm_chk #(.RESET_CYC(RESET_CYC)) i_chk (.core_clk, .reset_n, .swd_in,
   .swd_oe, .cmd_valid, .cmd_code, .cmd_ready, .done, .rd_bit, .collided, .attn_seen);

// [dv/swire_dev_model.sv]
// behavioural sensor device at the far end of the line
`timescale 1ns/1ns
`include "swire_defines.svh"
module swire_dev_model (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // line level, own pull-down
   input  wire logic line,
   output logic      pull,
   // bench asks for a read-one answer or an attention
   input  wire logic stretch,
   input  wire logic attn_req // new results ready to report
);
   logic [15:0] lo_len, hold; // low time, own drive left
   logic [4:0]  bits;         // data bits since bus reset
   logic        line_q;
   assign pull = hold != 16'h0;
   // time each low, count data bits, start own drives
   always_ff @(posedge core_clk)
   begin
      line_q <= line;
      lo_len <= line ? 16'h0 : lo_len + 16'h1;
      hold   <= hold - {15'h0, pull};
      if (!reset_n)
         {lo_len, hold, bits} <= '0;
      else if (line && !line_q)
         bits <= lo_len >= `THR_RESET_CYC ? 5'h0
            : bits + 5'(lo_len < `THR_START_CYC && bits < 5'he);
      else if (line_q && !line && !pull && attn_req && bits == 5'he)
         hold <= 16'h4650; // fixed own timebase, no training
      else if (line_q && !line && !pull && stretch)
         hold <= 16'h0bb8; // zero answers leave the line alone
   end
endmodule

// [dv/tb.sv]
// self-checking bench for the single-wire bus master
`timescale 1ns/1ns
`include "swire_defines.svh"
module tb;
   localparam int          RST_C = `RESET_MIN_CYC; // shortest legal power-up reset
   localparam logic [35:0] SEQ   = 36'h000032210;  // command of each table row
   logic core_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, stretch = 1'b0, attn_req = 1'b0;
   logic swd_in, swd_out, swd_oe, cmd_ready, done, rd_bit, collided, attn_seen, reset_seen;
   logic dev_pull;
   swire_pkg::cmd_e cmd_code = swire_pkg::CMD_WRITE0;
   int   miscompares = 0, samples_checked = 0, cycles = 0, attn_n = 0, rst_cnt = 0;
   // open-drain line with pull-up
   assign swd_in = (swd_oe ? swd_out : 1'b1) & !dev_pull;
   always #5 core_clk = !core_clk;
   swire_master #(.RESET_CYC(RST_C)) i_dut (.core_clk, .reset_n, .swd_in, .swd_out, .swd_oe,
      .cmd_valid, .cmd_code, .cmd_ready, .done, .rd_bit, .collided, .attn_seen, .reset_seen);
   // one master and a single device on the line
   swire_dev_model i_dev (.core_clk, .reset_n, .line(swd_in), .pull(dev_pull), .stretch,
      .attn_req);
   // event counts and cycle ceiling
   always @(negedge core_clk)
   begin
      cycles++;
      attn_n += int'(attn_seen === 1'b1);
      rst_cnt += int'(reset_seen === 1'b1);
      if (cycles == 120000) wrap_up(1);
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up(input int extra);
      miscompares += extra;
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // raise a command at a rising edge, hold it until taken, then wait for done
   task automatic send(input swire_pkg::cmd_e c);
      @(posedge core_clk);
      cmd_code <= c;
      cmd_valid <= 1'b1;
      do @(negedge core_clk); while (cmd_ready !== 1'b1);
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      do @(negedge core_clk); while (done !== 1'b1);
   endtask
   // power-up reset, eight training zeros, then ready
   task automatic t_power();
      int w;
      for (int k = 0; k < 9; k++)
      begin
         while (swd_oe !== 1'b1) @(negedge core_clk);
         check("drive_level", swd_out, 1'b0);
         for (w = 0; swd_oe === 1'b1; w++) @(negedge core_clk);
         check("pulse_len", w, k ? `SHORT_PULSE_CYC : RST_C);
      end
      while (cmd_ready !== 1'b1 && swd_oe !== 1'b1) @(negedge core_clk);
      check("extra_pulse", swd_oe, 1'b0);
      check("reset_seen", rst_cnt, 1);
   endtask
   // writes, reads of 0 and 1, start, then writes while attention waits for bit 14
   task automatic t_symbols();
      int a;
      for (int k = 0; k < 9; k++)
      begin
         a = attn_n;
         stretch <= k == 3;
         attn_req <= k inside {[5:7]};
         send(swire_pkg::cmd_e'(SEQ[4*k +: 3]));
         repeat (3) @(negedge core_clk);
         check("collided", collided, k == 7);
         check("attention", attn_n - a, k == 7);
         if (k inside {[2:3]}) check("rd_bit", rd_bit, k == 3);
      end
   endtask
   // reset, then the scenarios in order
   initial
   begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      t_power();
      t_symbols();
      wrap_up(0);
   end
endmodule
